// file: src/sar_adc_config_and_input_mux.sv
// register file, input mux select and conversion sequencer for the sar converter
// What this block does
// - in delayed tracking mode each conversion starts with exactly three step clock periods of tracking.
// - the step clock is the core clock divided by the 5-bit divider setting plus one.
// - left align clear puts the result right justified in the two result bytes, set puts it left justified.
// - left align matters only in 10-bit mode.
// - byte mode enable clear gives 10-bit conversion, set gives 8-bit conversion.
// - in 8-bit mode the left align bit is ignored.
// - the gain bit set gives gain one, clear gives the reduced gain.
// - selector codes map to port pins 0..15, temp sensor, regulator output, supply, ground, then nothing.
// - on the small package codes 01100..01111 are reserved instead of pins.
// - the three upper selector bits read zero and ignore writes.
// - normal mode gives 10-bit results.
`timescale 1ns/1ps
module sar_adc_config_and_input_mux
  import sar_cfg_pkg::*;
(
  input  wire logic        clock,            // 125 MHz core clock
  input  wire logic        sys_rst,          // synchronous reset, high
  input  wire logic        small_package,    // strap: 16-pin variant
  input  wire logic        reg_write,        // register write strobe
  input  wire logic        reg_read,         // register read strobe
  input  wire logic [7:0]  reg_addr,         // register address
  input  wire logic [7:0]  reg_wdata,        // write data
  output logic [7:0]       reg_rdata,        // read data, held
  input  wire logic        start_conversion, // one cycle start request
  input  wire logic        delayed_tracking, // delayed tracking mode
  input  wire logic        comparator_in,    // analog comparator output pin
  output logic [15:0]      port_pin_select,  // one-hot port pin select
  output logic             temp_sensor_select, // temp sensor routed
  output logic             regulator_select, // regulator output routed
  output logic             supply_select,    // supply routed
  output logic             ground_select,    // ground routed
  output logic             input_gain_select, // 1: gain one, 0: reduced
  output logic             tracking,         // input being tracked
  output logic [9:0]       dac_code,         // trial code to the dac
  output logic             busy,             // conversion in progress
  output logic             done_pulse,       // result valid, one cycle
  output logic [7:0]       result_high_byte, // result high byte
  output logic [7:0]       result_low_byte   // result low byte
);
  logic [4:0]  select_reg;
  logic [7:0]  config_reg;
  conv_state_t state_reg;
  conv_state_t state_next;
  logic [4:0]  track_count_reg;
  logic [3:0]  bit_index_reg;
  logic [9:0]  sar_reg;
  logic        cmp_meta_reg;
  logic        cmp_sync_reg;
  logic        pkg_meta_reg;
  logic        pkg_sync_reg;
  logic        divider_run;
  logic        step_pulse;
  logic        is_byte_mode;
  logic        is_left;
  logic [15:0] pin_decode;
  logic [9:0]  trial_bit;
  logic [9:0]  sar_with_trial;
  logic [9:0]  result_value;
  logic [15:0] placed;
  logic        last_bit;
  logic        wr_select;
  logic        wr_config;
  logic [7:0]  read_mux;

  // address decode
  assign wr_select = reg_write && (reg_addr == input_select_addr);
  assign wr_config = reg_write && (reg_addr == configuration_addr);

  assign read_mux = (reg_addr == input_select_addr)  ? {3'h0, select_reg} :
                    (reg_addr == configuration_addr) ? config_reg : 8'h00;

  // register storage and read data
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      select_reg <= input_select_reset[4:0];
      config_reg <= configuration_reset;
      reg_rdata  <= 8'h00;
    end else begin
      if (wr_select) select_reg <= reg_wdata[4:0];
      if (wr_config) config_reg <= reg_wdata;
      if (reg_read) reg_rdata <= read_mux;
    end
  end

  assign is_byte_mode = config_reg[byte_mode_bit];
  // left align only in 10-bit mode
  assign is_left      = config_reg[left_align_bit] && !is_byte_mode;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pin
      assign pin_decode[g] = (select_reg == 5'(g)) &&
                             !(pkg_sync_reg && (select_reg >= sel_first_reserved) &&
                               (select_reg <= sel_last_port));
    end
  endgenerate

  // mux select outputs, 10100 upward selects nothing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_pin_select    <= 16'h0000;
      temp_sensor_select <= 1'b0;
      regulator_select   <= 1'b0;
      supply_select      <= 1'b0;
      ground_select      <= 1'b0;
      input_gain_select  <= 1'b1;
    end else begin
      port_pin_select    <= pin_decode;
      temp_sensor_select <= (select_reg == sel_temp_sensor);
      regulator_select   <= (select_reg == sel_regulator_output);
      supply_select      <= (select_reg == sel_supply);
      ground_select      <= (select_reg == sel_ground);
      input_gain_select  <= config_reg[gain_bit];
    end
  end

  // two-stage synchronisers on the comparator and the package strap
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      pkg_meta_reg <= 1'b0;
      pkg_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= comparator_in;
      cmp_sync_reg <= cmp_meta_reg;
      pkg_meta_reg <= small_package;
      pkg_sync_reg <= pkg_meta_reg;
    end
  end

  // divider starts with the request, so the first step period is as long as the rest;
  // the comparator path needs a divider setting of 3 or more to settle before each decision
  assign divider_run = (state_next != st_idle);

  step_clock_divider_gen u_div (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .run        (divider_run),
    .divide_by  (config_reg[divider_lsb +: 5]),
    .step_pulse (step_pulse)
  );

  // trial bit and stop point; 8-bit mode stops two bits early
  assign trial_bit      = 10'h001 << bit_index_reg;
  assign sar_with_trial = sar_reg | trial_bit;
  assign last_bit       = is_byte_mode ? (bit_index_reg == (conversion_bits_full - conversion_bits_byte))
                                       : (bit_index_reg == 4'h0);

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (start_conversion) state_next = delayed_tracking ? st_track : st_step;
      end
      st_track: begin
        if (step_pulse && track_count_reg == tracking_steps - 5'h01) state_next = st_step;
      end
      st_step: begin
        if (step_pulse && last_bit) state_next = st_done;
      end
      st_done: state_next = st_idle;
      default: state_next = st_idle;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg       <= st_idle;
      track_count_reg <= 5'h00;
      bit_index_reg   <= 4'h9;
      sar_reg         <= 10'h000;
    end else begin
      state_reg <= state_next;
      if (state_reg == st_idle) begin
        track_count_reg <= 5'h00;
        bit_index_reg   <= conversion_bits_full - 4'h1;
        sar_reg         <= 10'h000;
      end else if (step_pulse && state_reg == st_track) begin
        track_count_reg <= track_count_reg + 5'h01;
      end else if (step_pulse && state_reg == st_step) begin
        // keep the trial bit when the comparator says input is above
        sar_reg       <= cmp_sync_reg ? sar_with_trial : sar_reg;
        bit_index_reg <= bit_index_reg - 4'h1;
      end
    end
  end

  // 8-bit result keeps its top-aligned bits, lower two zero
  assign result_value = is_byte_mode ? {sar_reg[9:2], 2'b00} : sar_reg;
  // placement in the two result bytes
  assign placed = is_left ? {result_value, 6'h00} : {6'h00, result_value};

  // outputs and result bytes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tracking         <= 1'b0;
      dac_code         <= 10'h000;
      busy             <= 1'b0;
      done_pulse       <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end else begin
      tracking   <= (state_next == st_track);
      dac_code   <= (state_reg == st_step) ? sar_with_trial : sar_reg;
      busy       <= (state_next != st_idle);
      done_pulse <= (state_reg == st_done);
      if (state_reg == st_done) begin
        result_high_byte <= placed[15:8];
        result_low_byte  <= placed[7:0];
      end
    end
  end
endmodule : sar_adc_config_and_input_mux

// file: src/sar_cfg_pkg.sv
// constants shared by the converter control block
package sar_cfg_pkg;
  localparam logic [7:0] input_select_addr     = 8'hbb;
  localparam logic [7:0] configuration_addr    = 8'hbc;
  localparam logic [7:0] input_select_reset    = 8'h1f;
  localparam logic [7:0] configuration_reset   = 8'hf9;
  localparam int         divider_lsb           = 3;
  localparam int         left_align_bit        = 2;
  localparam int         byte_mode_bit         = 1;
  localparam int         gain_bit              = 0;
  localparam logic [4:0] tracking_steps        = 5'h03;
  localparam logic [3:0] conversion_bits_full  = 4'ha;
  localparam logic [3:0] conversion_bits_byte  = 4'h8;
  localparam logic [4:0] sel_temp_sensor       = 5'h10;
  localparam logic [4:0] sel_regulator_output  = 5'h11;
  localparam logic [4:0] sel_supply            = 5'h12;
  localparam logic [4:0] sel_ground            = 5'h13;
  localparam logic [4:0] sel_first_reserved    = 5'h0c;
  localparam logic [4:0] sel_last_port         = 5'h0f;
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_track = 4'b0010,
    st_step  = 4'b0100,
    st_done  = 4'b1000
  } conv_state_t;
endpackage : sar_cfg_pkg

// file: src/step_clock_divider_gen.sv
// divider that makes the conversion step clock enable
`timescale 1ns/1ps
module step_clock_divider_gen
  import sar_cfg_pkg::*;
(
  input  wire logic       clock,        // core clock
  input  wire logic       sys_rst,      // synchronous reset, high
  input  wire logic       run,          // count while high
  input  wire logic [4:0] divide_by,    // setting, step = clock/(setting+1)
  output logic            step_pulse    // one cycle per step period
);
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic       wrap;

  // wrap when the count reaches the setting
  assign wrap       = (count_reg >= divide_by);
  assign count_next = wrap ? 5'h00 : count_reg + 5'h01;

  always_ff @(posedge clock) begin
    if (sys_rst || !run) begin
      count_reg  <= 5'h00;
      step_pulse <= 1'b0;
    end else begin
      count_reg  <= count_next;
      step_pulse <= wrap;
    end
  end
endmodule : step_clock_divider_gen

// file: verification/analog_source_model.sv
// analog sources behind the converter input mux
`timescale 1ns/1ps
module analog_source_model (
  input  wire logic [0:0]  clock,              // core clock
  input  wire logic [9:0]  base_level,         // pin level seed
  input  wire logic [15:0] port_pin_select,    // pin select
  input  wire logic        temp_sensor_select, // temp sensor
  input  wire logic        regulator_select,   // regulator
  input  wire logic        supply_select,      // supply
  input  wire logic        ground_select,      // ground
  input  wire logic [9:0]  dac_code,           // trial code
  output logic             comparator_in       // above trial
);
  int idx, lvl;
  logic toggle_reg = 1'b0;
  // level of the routed source, -1 when nothing is routed
  always_comb begin
    idx = 0;
    for (int i = 0; i < 16; i++) if (port_pin_select[i]) idx = i;
    lvl = |port_pin_select ? (base_level + idx * 40) % 1024 : temp_sensor_select ? int'(base_level) :
          regulator_select ? 512 : supply_select ? 1023 : ground_select ? 0 : -1;
  end
  // an open input gives a toggling comparator
  always @(posedge clock) toggle_reg <= ~toggle_reg;
  // the comparator answers at once; a flop here would add to the synchroniser delay
  assign comparator_in = (lvl < 0) ? toggle_reg : (lvl >= int'(dac_code));
endmodule : analog_source_model

// file: verification/sar_adc_config_and_input_mux_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_config_and_input_mux_tb;
  import sar_cfg_pkg::*;
  logic       clock = 0, sys_rst = 1, small_package = 0, reg_write = 0, reg_read = 0;
  logic       start_conversion = 0, delayed_tracking = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [9:0] base_level = 10'h155;
  wire  [7:0] reg_rdata, result_high_byte, result_low_byte;
  wire [15:0] port_pin_select;
  wire  [9:0] dac_code;
  wire        temp_sensor_select, regulator_select, supply_select, ground_select;
  wire        input_gain_select, comparator_in, tracking, busy, done_pulse;
  int         num_errors = 0, n_tests = 0, seed = 34;
  int         sels[8] = '{0, 5, 11, 15, 16, 17, 18, 19};
  int         divs[8] = '{7, 3, 12, 31, 4, 3, 5, 9};
  sar_adc_config_and_input_mux uut (.clock, .sys_rst, .small_package, .reg_write, .reg_read, .reg_addr,
    .reg_wdata, .reg_rdata, .start_conversion, .delayed_tracking, .comparator_in, .port_pin_select,
    .temp_sensor_select, .regulator_select, .supply_select, .ground_select, .input_gain_select, .tracking,
    .dac_code, .busy, .done_pulse, .result_high_byte, .result_low_byte);
  analog_source_model src (.clock, .base_level, .port_pin_select, .temp_sensor_select, .regulator_select,
    .supply_select, .ground_select, .dac_code, .comparator_in);
  initial forever #4 clock = ~clock;
  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // register write with an idle cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock) #1 reg_write = 0;
    @(posedge clock) #1;
  endtask : wr
  // register read, data lands at the taking edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_read = 1;
    reg_addr = a;
    @(posedge clock) #1 reg_read = 0;
    chk(nm, {8'h00, reg_rdata}, {8'h00, exp});
    @(posedge clock) #1;
  endtask : rdc
  // one conversion against the ideal sar result
  task automatic conv(input logic [4:0] sel, input logic trk, input logic [7:0] cfg);
    int v, k, t;
    logic [15:0] e;
    v = sel < 16 ? (base_level + sel * 40) % 1024 : sel == 5'h10 ? int'(base_level) :
        sel == 5'h11 ? 512 : sel == 5'h12 ? 1023 : 0;
    e = cfg[1] ? {6'h00, 10'(v & 1020)} : cfg[2] ? {10'(v), 6'h00} : {6'h00, 10'(v)};
    t = 0;
    wr(configuration_addr, cfg);
    wr(input_select_addr, {3'h7, sel});
    delayed_tracking = trk;
    start_conversion = 1;
    @(posedge clock) #1 start_conversion = 0;
    chk("busy start", {15'h0000, busy}, 16'h0001);
    for (k = 0; k < 2000 && done_pulse !== 1'b1; k++) begin
      if (tracking === 1'b1) t++;
      @(posedge clock) #1;
    end
    chk("done seen", {15'h0000, done_pulse}, 16'h0001);
    chk("busy end", {15'h0000, busy}, 16'h0000);
    chk("track length", 16'(t), 16'(trk ? 3 * (int'(cfg[7:3]) + 1) : 0));
    chk("result", {result_high_byte, result_low_byte}, e);
    chk("gain", {15'h0000, input_gain_select}, {15'h0000, cfg[0]});
    rdc(configuration_addr, cfg, "config");
  endtask : conv
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clock);
    #1 sys_rst = 0;
    rdc(input_select_addr, input_select_reset, "select reset");
    rdc(configuration_addr, configuration_reset, "config reset");
    rdc(8'h40, 8'h00, "unmapped");
    wr(input_select_addr, 8'hff);
    rdc(input_select_addr, 8'h1f, "select upper");
    for (int i = 0; i < 8; i++) begin
      base_level = 10'($random(seed));
      conv(5'(sels[i]), 1'(i % 2), {5'(divs[i]), 2'(i % 4), 1'($random(seed))});
      $display("conversion test %0d done", i);
    end
    small_package = 1;
    repeat (2) @(posedge clock) #1;
    wr(input_select_addr, 8'h0c);
    chk("reserved pin", port_pin_select, 16'h0000);
    wr(input_select_addr, 8'h0b);
    chk("pin eleven", port_pin_select, 16'h0800);
    $display("mux test done");
    wrap_up();
  end
endmodule : sar_adc_config_and_input_mux_tb

// file: verification/sar_checker.sv
// assertions on the converter control ports
`timescale 1ns/1ps
module sar_checker
  import sar_cfg_pkg::*;
(
  input wire logic        clock, sys_rst, small_package, reg_write, reg_read, // control
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, // register bus
  input wire logic [15:0] port_pin_select, // pins
  input wire logic        ground_select, tracking, done_pulse, // status
  input wire logic [7:0]  result_high_byte, result_low_byte // result
);
  logic [7:0] cfg_reg;
  int         cnt_reg, exp_reg;
  // configuration shadow and tracking length
  always_ff @(posedge clock) begin
    cfg_reg <= sys_rst ? configuration_reset : (reg_write && reg_addr == configuration_addr) ? reg_wdata : cfg_reg;
    cnt_reg <= tracking ? cnt_reg + 1 : 0;
    exp_reg <= 3 * (int'(cfg_reg[7:3]) + 1);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_track_len: assert property ($fell(tracking) |-> cnt_reg == exp_reg)
    else $error("bad tracking length");
  chk_pin_onehot: assert property ($onehot0({port_pin_select, ground_select}))
    else $error("bad mux select");
  chk_small_rsvd: assert property (small_package && $past(small_package, 3) |-> port_pin_select[15:12] == 4'h0)
    else $error("reserved pin routed");
  chk_ground_route: assert property (reg_write && reg_addr == input_select_addr && reg_wdata[4:0] == sel_ground
    |-> ##2 ground_select) else $error("ground not routed");
  chk_sel_upper: assert property (reg_read && reg_addr == input_select_addr |=> reg_rdata[7:5] == 3'h0)
    else $error("upper bits set");
  chk_right_align: assert property (done_pulse && cfg_reg[2:1] == 2'h0 |-> result_high_byte[7:2] == 6'h00)
    else $error("bad right align");
  chk_left_align: assert property (done_pulse && cfg_reg[2:1] == 2'h2 |-> result_low_byte[5:0] == 6'h00)
    else $error("bad left align");
  chk_byte_fmt: assert property (done_pulse && cfg_reg[1] |-> result_high_byte[7:2] == 6'h00
    && result_low_byte[1:0] == 2'h0) else $error("bad byte format");
  cover property ($rose(tracking));
  cover property (done_pulse && cfg_reg[1]);
  cover property (done_pulse && cfg_reg[2:1] == 2'h2);
endmodule : sar_checker
bind sar_adc_config_and_input_mux sar_checker u_chk (.clock, .sys_rst, .small_package, .reg_write, .reg_read,
  .reg_addr, .reg_wdata, .reg_rdata, .port_pin_select, .ground_select, .tracking, .done_pulse,
  .result_high_byte, .result_low_byte);
